// ===== design/pmx_pkg.sv
// pmx_pkg: constants, register indices and types for the port-0 pin mux block.
// assumes a 16-bit AHB-Lite byte address; registers are 16 bits in the low half of a word.
package pmx_pkg;

  // ===========================================================================
  // widths
  localparam int unsigned P0_PINS   = 6;
  localparam int unsigned A_PINS    = 6;
  localparam int unsigned I2S_PINS  = 4;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned CLK_SRC_W = 2;

  // ===========================================================================
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_BUS_SEL  = 16'h1c00;
  localparam logic [15:0] IDX_PULL_A   = 16'h1c17;
  localparam logic [15:0] IDX_PULL_B   = 16'h1c18;
  localparam logic [15:0] IDX_PULL_C   = 16'h1c19;
  localparam logic [15:0] IDX_CLK_SRC  = 16'h1c24;
  localparam logic [15:0] IDX_STATUS3  = 16'h1c30;

  // ===========================================================================
  // field positions
  localparam int unsigned BUS_SEL_AMODE_LSB = 0;
  localparam int unsigned BUS_SEL_P0SEL_LSB = 10;
  localparam int unsigned CLK_SRC_LSB       = 0;
  localparam int unsigned STATUS3_OFF_BIT   = 0;

  // ===========================================================================
  // values after reset
  localparam logic [1:0]       RST_P0SEL   = 2'h0;
  localparam logic [5:0]       RST_AMODE   = 6'h00;
  localparam logic [REG_W-1:0] RST_PULL    = 16'h0000;
  localparam logic [1:0]       RST_CLK_SRC = 2'h0;
  localparam logic             RST_CLOCK_OUT_OFF_BIT  = 1'b0;

  // ===========================================================================
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0] {P0_MMC, P0_I2S, P0_GPIO, P0_RSVD} pmx_p0sel_type;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RD_WAIT, BUS_RD_DONE} pmx_bus_state_type;

endpackage : pmx_pkg

// ===== design/pmx_holder.sv
// pmx_holder: bus-holder keeper state for a bank of pads.
// assumes pad levels arrive synchronous to hclk.
`timescale 1ns/100ps
module pmx_holder
  import pmx_pkg::*;
#(
  parameter int unsigned WIDTH = 12
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hold_en,
  input  wire logic [WIDTH-1:0] pad_in,
  output logic      [WIDTH-1:0] hold_level
);

  initial begin
    if (WIDTH < 1) $error("pmx_holder: WIDTH must be at least 1");
  end

  // ===========================================================================
  // keeper: follows the pad, so a strong external drive flips it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_level <= '0;
    end else begin
      hold_level <= pad_in; // R9
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_holder_follow: assert property ( // R9
    hold_en && $changed(pad_in) |=> hold_level == $past(pad_in))
    else $error("holder did not follow a forced pad level");

  a_holder_keep: assert property ( // R9
    hold_en && $stable(pad_in) [*2] |-> hold_level == pad_in)
    else $error("holder lost the last pad level");

endmodule : pmx_holder

// ===== design/pmx_top.sv
// pmx_top: port-0 and address pin mux, pull control, bus holders, debug clock out.
// assumes a single AHB-Lite master, inputs synchronous to hclk, core power as a level.
`timescale 1ns/100ps

// Summary of operation
// [R1] select field 00 memory card port, 01 audio serial port, 10 GPIO 0-5.
// [R2] in audio mode, card data pins 2 and 3 act as GPIO 4 and 5.
// [R3] address select bit 0 gives memory address line, 1 gives GPIO.
// [R4] six select bits; address line 15+k pairs with GPIO 21+k.
// [R5] first inhibit register, bits 0-5, disable each port-0 pin pulldown.
// [R6] three inhibit registers at indices 1C17h-1C19h; software inhibits externally pulled pins.
// [R7] every GPIO pin has an internal pull available.
// [R8] core power on: holders off, pulls act; off: holders on, pulls off.
// [R9] an active holder keeps the last pad level and follows a strong drive.
// [R10] source field picks which clock reaches the debug clock pin.
// [R11] status bit set disables the debug clock pin.
// [R12] software resets affected peripherals after changing the mux selection.
// [R13] select code 11 leaves all six port-0 pins as inputs.
module pmx_top
  import pmx_pkg::*;
#(
  parameter int unsigned NUM_CLK_SRC = 4
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [ADDR_W-1:0]      haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [31:0]            hrdata,
  input  wire logic                   core_power_on,
  input  wire logic [P0_PINS-1:0]     mmc_out,
  input  wire logic [P0_PINS-1:0]     mmc_oe,
  output logic      [P0_PINS-1:0]     mmc_in,
  input  wire logic [I2S_PINS-1:0]    i2s_out,
  input  wire logic [I2S_PINS-1:0]    i2s_oe,
  output logic      [I2S_PINS-1:0]    i2s_in,
  input  wire logic [P0_PINS-1:0]     gp_lo_out,
  input  wire logic [P0_PINS-1:0]     gp_lo_oe,
  output logic      [P0_PINS-1:0]     gp_lo_in,
  input  wire logic [A_PINS-1:0]      emif_addr_out,
  input  wire logic                   emif_addr_oe,
  input  wire logic [A_PINS-1:0]      gp_hi_out,
  input  wire logic [A_PINS-1:0]      gp_hi_oe,
  output logic      [A_PINS-1:0]      gp_hi_in,
  input  wire logic [P0_PINS-1:0]     p0_pad_in,
  output logic      [P0_PINS-1:0]     p0_pad_out,
  output logic      [P0_PINS-1:0]     p0_pad_oe,
  input  wire logic [A_PINS-1:0]      a_pad_in,
  output logic      [A_PINS-1:0]      a_pad_out,
  output logic      [A_PINS-1:0]      a_pad_oe,
  output logic      [REG_W-1:0]       pull_en_a,
  output logic      [REG_W-1:0]       pull_en_b,
  output logic      [REG_W-1:0]       pull_en_c,
  output logic                        bus_hold_en,
  output logic      [P0_PINS+A_PINS-1:0] bus_hold_level,
  input  wire logic [NUM_CLK_SRC-1:0] clk_src_in,
  output logic                        debug_clock_output_pin,
  output logic                        pinmux_changed
);

  initial begin
    if (NUM_CLK_SRC < 1 || NUM_CLK_SRC > (1 << CLK_SRC_W))
      $error("pmx_top: NUM_CLK_SRC out of range for the source field");
  end

  // ===========================================================================
  // address decode helpers
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    idx_hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (a[1:0] == 2'h0);
  endfunction : idx_hit

  // ===========================================================================
  // registers
  pmx_bus_state_type   state_r;
  pmx_bus_state_type   state_nxt;
  logic [ADDR_W-1:0]   addr_r;
  logic [2:0]          size_r;
  logic [1:0]          port0_select_field_r;
  logic [A_PINS-1:0]   amode_r;
  logic [REG_W-1:0]    pull_inhibit_reg_a_r;
  logic [REG_W-1:0]    pull_inhibit_reg_b_r;
  logic [REG_W-1:0]    pull_inhibit_reg_c_r;
  logic [CLK_SRC_W-1:0] clock_out_source_field_r;
  logic                clock_out_off_bit_r;
  logic                accept;
  logic                wr_en;
  logic                wr_bus_sel;
  logic [31:0]         rd_nxt;
  logic [1:0]          p0sel_nxt;
  logic [A_PINS-1:0]   amode_nxt;
  pmx_p0sel_type       p0sel;

  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wr_en  = (state_r == BUS_WRITE) && (size_r == HSIZE_WORD);
  assign wr_bus_sel = wr_en && idx_hit(addr_r, IDX_BUS_SEL);
  assign p0sel_nxt  = hwdata[BUS_SEL_P0SEL_LSB +: 2];
  assign amode_nxt  = hwdata[BUS_SEL_AMODE_LSB +: A_PINS];
  assign p0sel      = pmx_p0sel_type'(port0_select_field_r);

  // ===========================================================================
  // AHB-Lite slave: writes with no wait, reads with one wait state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
        if (accept) begin
          state_nxt = hwrite ? BUS_WRITE : BUS_RD_WAIT;
        end else begin
          state_nxt = BUS_IDLE;
        end
      end
      BUS_RD_WAIT: state_nxt = BUS_RD_DONE;
      default:     state_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= BUS_IDLE;
      addr_r  <= '0;
      size_r  <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (accept && state_r != BUS_RD_WAIT) begin
        addr_r <= haddr;
        size_r <= hsize;
      end
    end
  end

  assign hreadyout = (state_r != BUS_RD_WAIT);
  assign hresp     = 1'b0;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (idx_hit(addr_r, IDX_BUS_SEL)) begin
      rd_nxt[BUS_SEL_P0SEL_LSB +: 2]      = port0_select_field_r;
      rd_nxt[BUS_SEL_AMODE_LSB +: A_PINS] = amode_r;
    end else if (idx_hit(addr_r, IDX_PULL_A)) begin
      rd_nxt[REG_W-1:0] = pull_inhibit_reg_a_r;
    end else if (idx_hit(addr_r, IDX_PULL_B)) begin
      rd_nxt[REG_W-1:0] = pull_inhibit_reg_b_r;
    end else if (idx_hit(addr_r, IDX_PULL_C)) begin
      rd_nxt[REG_W-1:0] = pull_inhibit_reg_c_r;
    end else if (idx_hit(addr_r, IDX_CLK_SRC)) begin
      rd_nxt[CLK_SRC_LSB +: CLK_SRC_W] = clock_out_source_field_r;
    end else if (idx_hit(addr_r, IDX_STATUS3)) begin
      rd_nxt[STATUS3_OFF_BIT] = clock_out_off_bit_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state_r == BUS_RD_WAIT) begin
      hrdata <= rd_nxt;
    end
  end

  // ===========================================================================
  // software registers; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port0_select_field_r <= RST_P0SEL;
      amode_r              <= RST_AMODE;
    end else if (wr_bus_sel) begin
      port0_select_field_r <= p0sel_nxt;
      amode_r              <= amode_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_inhibit_reg_a_r <= RST_PULL;
      pull_inhibit_reg_b_r <= RST_PULL;
      pull_inhibit_reg_c_r <= RST_PULL;
    end else if (wr_en) begin
      if (idx_hit(addr_r, IDX_PULL_A)) pull_inhibit_reg_a_r <= hwdata[REG_W-1:0]; // R6
      if (idx_hit(addr_r, IDX_PULL_B)) pull_inhibit_reg_b_r <= hwdata[REG_W-1:0]; // R6
      if (idx_hit(addr_r, IDX_PULL_C)) pull_inhibit_reg_c_r <= hwdata[REG_W-1:0]; // R6
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_out_source_field_r <= RST_CLK_SRC;
      clock_out_off_bit_r      <= RST_CLOCK_OUT_OFF_BIT;
    end else if (wr_en) begin
      if (idx_hit(addr_r, IDX_CLK_SRC))
        clock_out_source_field_r <= hwdata[CLK_SRC_LSB +: CLK_SRC_W];
      if (idx_hit(addr_r, IDX_STATUS3))
        clock_out_off_bit_r <= hwdata[STATUS3_OFF_BIT];
    end
  end

  // pulses for one cycle when a bus-select write changes the port-0 or address mux selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pinmux_changed <= 1'b0;
    end else begin
      pinmux_changed <= wr_bus_sel && // R12
        (p0sel_nxt != port0_select_field_r || amode_nxt != amode_r);
    end
  end

  // ===========================================================================
  // port-0 pin routing; pads registered, so one cycle behind the peripherals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_pad_out <= '0;
      p0_pad_oe  <= '0;
      mmc_in     <= '0;
      i2s_in     <= '0;
      gp_lo_in   <= '0;
    end else begin
      p0_pad_out <= '0;
      p0_pad_oe  <= '0;
      mmc_in     <= '0;
      i2s_in     <= '0;
      gp_lo_in   <= '0;
      case (p0sel)
        P0_MMC: begin
          p0_pad_out <= mmc_out; // R1
          p0_pad_oe  <= mmc_oe; // R1
          mmc_in     <= p0_pad_in;
        end
        P0_I2S: begin
          p0_pad_out <= {gp_lo_out[5:4], i2s_out}; // R2
          p0_pad_oe  <= {gp_lo_oe[5:4], i2s_oe}; // R2
          i2s_in     <= p0_pad_in[I2S_PINS-1:0];
          gp_lo_in   <= {p0_pad_in[5:4], 4'h0}; // R2
        end
        P0_GPIO: begin
          p0_pad_out <= gp_lo_out; // R1
          p0_pad_oe  <= gp_lo_oe; // R1
          gp_lo_in   <= p0_pad_in;
        end
        default: begin
          // reserved code: pads stay undriven inputs
          p0_pad_oe <= '0; // R13
        end
      endcase
    end
  end

  // ===========================================================================
  // address pin routing, one select bit per pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_pad_out <= '0;
      a_pad_oe  <= '0;
      gp_hi_in  <= '0;
    end else begin
      for (int k = 0; k < A_PINS; k++) begin
        a_pad_out[k] <= amode_r[k] ? gp_hi_out[k] : emif_addr_out[k]; // R3 R4
        a_pad_oe[k]  <= amode_r[k] ? gp_hi_oe[k] : emif_addr_oe; // R3 R4
        gp_hi_in[k]  <= amode_r[k] & a_pad_in[k]; // R4
      end
    end
  end

  // ===========================================================================
  // pulls and bus holders follow core power
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_en_a   <= '0;
      pull_en_b   <= '0;
      pull_en_c   <= '0;
      bus_hold_en <= 1'b0;
    end else begin
      pull_en_a   <= core_power_on ? ~pull_inhibit_reg_a_r : '0; // R5 R8
      pull_en_b   <= core_power_on ? ~pull_inhibit_reg_b_r : '0; // R7 R8
      pull_en_c   <= core_power_on ? ~pull_inhibit_reg_c_r : '0; // R8
      bus_hold_en <= ~core_power_on; // R8
    end
  end

  pmx_holder #(
    .WIDTH (P0_PINS + A_PINS)
  ) u_pmx_holder (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hold_en    (bus_hold_en),
    .pad_in     ({a_pad_in, p0_pad_in}),
    .hold_level (bus_hold_level)
  );

  // ===========================================================================
  // debug clock out; sampled at hclk, so only sources well below 50 MHz pass clean
  logic clk_pick;

  always_comb begin
    clk_pick = 1'b0;
    for (int s = 0; s < NUM_CLK_SRC; s++) begin
      if (clock_out_source_field_r == s[CLK_SRC_W-1:0]) clk_pick = clk_src_in[s]; // R10
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_clock_output_pin <= 1'b0;
    end else begin
      debug_clock_output_pin <= clock_out_off_bit_r ? 1'b0 : clk_pick; // R10 R11
    end
  end

  // ===========================================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr_pull_a;
    wr_en && idx_hit(addr_r, IDX_PULL_A);
  endsequence

  sequence s_pull_a_seen;
    pull_inhibit_reg_a_r == $past(hwdata[REG_W-1:0]) ##1
      (!$past(core_power_on) || pull_en_a == ~$past(pull_inhibit_reg_a_r));
  endsequence

  a_mmc_route: assert property ( // R1
    p0sel == P0_MMC |=> p0_pad_out == $past(mmc_out) && p0_pad_oe == $past(mmc_oe))
    else $error("memory card mode did not reach the port-0 pads");

  a_i2s_gpio_pins: assert property ( // R2
    p0sel == P0_I2S |=> p0_pad_oe == {$past(gp_lo_oe[5:4]), $past(i2s_oe)})
    else $error("audio mode pin split is wrong");

  a_gpio_route: assert property ( // R1
    p0sel == P0_GPIO |=> p0_pad_out == $past(gp_lo_out))
    else $error("gpio mode did not reach the port-0 pads");

  a_addr_select: assert property ( // R3
    amode_r[0] == 1'b0 && $stable(amode_r) |=> a_pad_out[0] == $past(emif_addr_out[0]))
    else $error("address select 0 did not give the address line");

  a_addr_gpio: assert property ( // R4
    amode_r[5] && $stable(amode_r) |=> a_pad_oe[5] == $past(gp_hi_oe[5]))
    else $error("address pin 20 not paired with gpio 26");

  a_pull_write: assert property ( // R5
    s_wr_pull_a |=> s_pull_a_seen)
    else $error("pulldown inhibit write did not take effect");

  a_pull_b_write: assert property ( // R6
    wr_en && idx_hit(addr_r, IDX_PULL_B) |=> pull_inhibit_reg_b_r == $past(hwdata[REG_W-1:0]))
    else $error("second inhibit register did not store");

  a_gpio_pull: assert property ( // R7
    core_power_on && $stable(pull_inhibit_reg_b_r) |=> pull_en_b == ~$past(pull_inhibit_reg_b_r))
    else $error("gpio pull enable wrong while powered");

  a_power_off: assert property ( // R8
    !core_power_on |=> bus_hold_en && pull_en_a == '0 && pull_en_b == '0)
    else $error("holders or pulls wrong with core power off");

  a_clk_source: assert property ( // R10
    !clock_out_off_bit_r |=> debug_clock_output_pin == $past(clk_pick))
    else $error("debug clock source mismatch");

  a_clk_off: assert property ( // R11
    clock_out_off_bit_r [*2] |-> !debug_clock_output_pin)
    else $error("debug clock pin active while disabled");

  a_rsvd_safe: assert property ( // R13
    p0sel == P0_RSVD |=> p0_pad_oe == '0)
    else $error("reserved select code drives port-0 pads");

  a_read_wait: assert property (
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule : pmx_top

// ===== tb/pmx_board.sv
// pmx_board: board side of the twelve muxed pads, external drivers, pulls and keepers.
// assumes pad controls from pmx_top (bits 5:0 port 0, 11:6 address pins) and bench ext_*.
`timescale 1ns/100ps
module pmx_board
  import pmx_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic [11:0] pad_out,
  input  wire logic [11:0] pad_oe,
  input  wire logic [11:0] pull_en,
  input  wire logic        hold_en,
  input  wire logic [11:0] hold_level,
  input  wire logic [11:0] ext_val,
  input  wire logic [11:0] ext_en,
  output logic      [11:0] pad_in
);
  logic [11:0] last_r;
  logic [11:0] idle_lvl;

  // ==========================================================================
  // floating level
  // pulled pins sit low; with no pull and no keeper show the opposite of the
  // last level, so a stale copy never passes for a held value
  assign idle_lvl = ~pull_en & (hold_en ? hold_level : ~last_r);

  // ==========================================================================
  // pad resolution: device drive, then strong external drive, then idle
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & idle_lvl);

  always_ff @(posedge hclk) begin
    last_r <= pad_in;
  end
endmodule : pmx_board

// ===== tb/pmx_top_test.sv
// pmx_top_test: self-checking bench for the port-0 and address pin mux block.
// assumes pmx_top as the AHB-Lite slave and pmx_board as the pads around it.
`timescale 1ns/100ps
module pmx_top_test
  import pmx_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_power_on;
  logic [15:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd_data;
  logic [5:0]  mmc_out, mmc_oe, mmc_in, gp_lo_out, gp_lo_oe, gp_lo_in, emif_addr_out;
  logic [5:0]  gp_hi_out, gp_hi_oe, gp_hi_in, p0_pad_in, p0_pad_out, p0_pad_oe;
  logic [5:0]  a_pad_in, a_pad_out, a_pad_oe;
  logic [3:0]  i2s_out, i2s_oe, i2s_in, clk_src_in;
  logic        emif_addr_oe, bus_hold_en, debug_clock_output_pin, pinmux_changed, pm_seen;
  logic [15:0] pull_en_a, pull_en_b, pull_en_c;
  logic [11:0] bus_hold_level, ext_val, ext_en, pads_in;
  int          bad_count, num_checks;

  assign hready = hreadyout;
  assign p0_pad_in = pads_in[5:0];
  assign a_pad_in = pads_in[11:6];

  pmx_top #(.NUM_CLK_SRC(4)) u_pmx_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .core_power_on, .mmc_out, .mmc_oe, .mmc_in,
    .i2s_out, .i2s_oe, .i2s_in, .gp_lo_out, .gp_lo_oe, .gp_lo_in, .emif_addr_out,
    .emif_addr_oe, .gp_hi_out, .gp_hi_oe, .gp_hi_in, .p0_pad_in, .p0_pad_out,
    .p0_pad_oe, .a_pad_in, .a_pad_out, .a_pad_oe, .pull_en_a, .pull_en_b, .pull_en_c,
    .bus_hold_en, .bus_hold_level, .clk_src_in, .debug_clock_output_pin, .pinmux_changed
  );

  pmx_board u_pmx_board (
    .hclk, .pad_out({a_pad_out, p0_pad_out}), .pad_oe({a_pad_oe, p0_pad_oe}),
    .pull_en({pull_en_b[5:0], pull_en_a[5:0]}), .hold_en(bus_hold_en),
    .hold_level(bus_hold_level), .ext_val, .ext_en, .pad_in(pads_in)
  );

  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // no fixed latency assumed: sample hready at each edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) chk("hready wait", {31'h0, hreadyout}, 32'h0000_0001);
    rd_data = hrdata;
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {idx[13:0], 2'b00};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus

  task automatic set_mux(input logic [1:0] m, input logic [5:0] am);
    bus(1'b1, IDX_BUS_SEL, {20'h0_0000, m, 4'h0, am});
  endtask : set_mux

  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask : settle

  always @(posedge hclk) if (pinmux_changed === 1'b1) pm_seen = 1'b1;

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk("pull_en_a", pull_en_a, 32'h0000_ffff);
    chk("hold_en", bus_hold_en, 32'h0);
    bus(1'b1, 16'h1c01, 32'h0000_ffff);
    bus(1'b0, 16'h1c01, 32'h0);
    chk("unmapped", rd_data, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    bus(1'b0, IDX_BUS_SEL, 32'h0);
    chk("bus_sel", rd_data, 32'h0);
  endtask : t_reset

  task automatic t_modes();
    logic [5:0] eo, em, eg;
    logic [3:0] es;
    for (int m = 0; m < 4; m++) begin
      pm_seen = 1'b0;
      set_mux(m[1:0], 6'h00);
      @(posedge hclk);
      mmc_out <= 6'h2d; mmc_oe <= 6'h3f; i2s_out <= 4'ha; i2s_oe <= 4'hf;
      gp_lo_out <= 6'h13; gp_lo_oe <= 6'h3f; ext_en <= 12'h000;
      settle();
      chk("pinmux_changed", pm_seen, {31'h0, m != 0});
      case (m)
        0: begin eo = 6'h2d; em = 6'h2a; es = 4'h0; eg = 6'h00; end
        1: begin eo = 6'h1a; em = 6'h00; es = 4'ha; eg = 6'h20; end
        2: begin eo = 6'h13; em = 6'h00; es = 4'h0; eg = 6'h2a; end
        default: begin eo = 6'h00; em = 6'h00; es = 4'h0; eg = 6'h00; end
      endcase
      chk("p0_pad_oe", p0_pad_oe, (m == 3) ? 32'h0 : 32'h0000_003f);
      if (m != 3) chk("p0_pad_out", p0_pad_out, eo);
      @(posedge hclk);
      mmc_oe <= 6'h00; i2s_oe <= 4'h0; gp_lo_oe <= 6'h00;
      ext_en <= 12'h03f; ext_val <= 12'h02a;
      settle();
      chk("mmc_in", mmc_in, em);
      chk("i2s_in", i2s_in, es);
      chk("gp_lo_in", gp_lo_in, eg);
    end
  endtask : t_modes

  task automatic t_addr();
    logic [5:0] am;
    for (int i = 0; i < 2; i++) begin
      am = i ? 6'h1a : 6'h25;
      set_mux(2'h0, am);
      @(posedge hclk);
      emif_addr_out <= 6'h0f; emif_addr_oe <= 1'b1; gp_hi_out <= 6'h30; gp_hi_oe <= 6'h3f;
      settle();
      chk("a_pad_out", a_pad_out, (6'h30 & am) | (6'h0f & ~am));
      chk("a_pad_oe", a_pad_oe, 32'h0000_003f);
      @(posedge hclk);
      emif_addr_oe <= 1'b0; gp_hi_oe <= 6'h00; ext_en <= 12'hfc0; ext_val <= 12'hcc0;
      settle();
      chk("gp_hi_in", gp_hi_in, 6'h33 & am);
    end
  endtask : t_addr

  task automatic t_pull();
    logic [15:0] idx[3] = '{IDX_PULL_A, IDX_PULL_B, IDX_PULL_C};
    logic [15:0] val[3] = '{16'h003f, 16'h0005, 16'ha000};
    for (int i = 0; i < 3; i++) bus(1'b1, idx[i], {16'hffff, val[i]});
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, idx[i], 32'h0);
      chk("pull reg", rd_data, {16'h0000, val[i]});
    end
    settle();
    chk("pull_en_a", pull_en_a, 32'h0000_ffc0);
    chk("pull_en_b", pull_en_b, 32'h0000_fffa);
    chk("pull_en_c", pull_en_c, 32'h0000_5fff);
    for (int i = 0; i < 3; i++) bus(1'b1, idx[i], 32'h0);
  endtask : t_pull

  task automatic t_hold();
    set_mux(2'h3, 6'h00);
    @(posedge hclk);
    ext_en <= 12'h03f; ext_val <= 12'h02a;
    settle();
    @(posedge hclk);
    core_power_on <= 1'b0;
    settle();
    chk("hold_en off", bus_hold_en, 32'h1);
    chk("pull_en_a off", pull_en_a, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      ext_en <= 12'h000;
      repeat (3) settle();
      chk("held level", bus_hold_level[5:0], i ? 6'h15 : 6'h2a);
      @(posedge hclk);
      ext_en <= 12'h03f; ext_val <= 12'h015;
      settle();
    end
    @(posedge hclk);
    core_power_on <= 1'b1;
    settle();
    chk("hold_en on", bus_hold_en, 32'h0);
    chk("pull_en_a on", pull_en_a, 32'h0000_ffff);
  endtask : t_hold

  task automatic t_clk();
    @(posedge hclk);
    clk_src_in <= 4'b1010;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, IDX_CLK_SRC, k);
      settle();
      chk("clk out", debug_clock_output_pin, k == 1 || k == 3);
    end
    bus(1'b1, IDX_STATUS3, 32'h0000_0001);
    settle();
    chk("clk off", debug_clock_output_pin, 32'h0);
    bus(1'b1, IDX_STATUS3, 32'h0);
    settle();
    chk("clk on", debug_clock_output_pin, 32'h1);
  endtask : t_clk

  // ==========================================================================
  // clock, reset, sequence and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 16'h0000; htrans = 2'h0; hwrite = 1'b0;
    hsize = HSIZE_WORD; hwdata = 32'h0; core_power_on = 1'b1; mmc_out = 6'h00;
    mmc_oe = 6'h00; i2s_out = 4'h0; i2s_oe = 4'h0; gp_lo_out = 6'h00; gp_lo_oe = 6'h00;
    emif_addr_out = 6'h00; emif_addr_oe = 1'b0; gp_hi_out = 6'h00; gp_hi_oe = 6'h00;
    clk_src_in = 4'h0; ext_val = 12'h000; ext_en = 12'h000; pm_seen = 1'b0;
    bad_count = 0; num_checks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    t_reset();
    t_modes();
    t_addr();
    t_pull();
    t_hold();
    t_clk();
    results();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    results();
  end
endmodule : pmx_top_test
